/* File: verilog/quad_dac_defines.svh */
// constants for the quad converter serial load logic
`ifndef QUAD_DAC_DEFINES_SVH
`define QUAD_DAC_DEFINES_SVH
`define CODE_W 14
`define WORD_W 16
`define NUM_CH 4
`define SEL_HI_BIT 15
`define SEL_LO_BIT 14
`define CODE_MSB 13
`define PRESET_ZERO 14'h0000
`define PRESET_HALF 14'h2000
`define SDO_DELAY 17
`endif

/* File: verilog/quad_dac_pkg.sv */
// types for the quad converter serial load logic
`include "quad_dac_defines.svh"
package quad_dac_pkg;
    typedef logic [`CODE_W-1:0] code_t;
    typedef struct packed {
        code_t [`NUM_CH-1:0] ch;
    } code_bank_t;
    typedef struct packed {
        logic [`SDO_DELAY-1:0] shift;
        logic [1:0] sel_sync;
        logic [2:0] frame_tgl_sync;
    } core_state_t;
    typedef struct packed {
        logic [1:0] load_sync;
        logic [1:0] level_sync;
        logic [2:0] init_done;
    } sys_state_t;
endpackage

/* File: verilog/quad_dac_serial_load_logic.sv */
// serial load, double buffer and preset logic of a quad 14-bit converter
`timescale 1ns/10ps
`include "quad_dac_defines.svh"
// ----------------------------------------------------------------
// Overview of operation
// - four channels each hold a 14-bit code
// - 16-bit words, most significant bit first
// - serial bit captured on serial clock rise
// - shift only while chip select low
// - only last 16 bits used at deselect
// - select rise loads addressed input register
// - load strobe updates all outputs together
// - async preset forces zero or half scale
// - bits 15:14 select channel, 13:0 code
// - strobe low transparent, high holds outputs
// - serial output lags input by 17 clocks
// - half scale 2000h, zero scale 0000h
// ----------------------------------------------------------------
module quad_dac_serial_load_logic (
    // system clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // serial link
    input wire logic serial_clk_i,
    input wire logic chip_sel_n_i,
    input wire logic serial_in_i,
    output logic serial_out_o,
    // control pins
    input wire logic load_outputs_n_i,
    input wire logic preset_n_i,
    input wire logic preset_level_i,
    // converter codes
    output quad_dac_pkg::code_bank_t input_regs_o,
    output quad_dac_pkg::code_bank_t dac_regs_o
);
    import quad_dac_pkg::*;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ----------------------------------------------------------------
    // link domain: shift register on the serial clock
    // ----------------------------------------------------------------
    // 17 stages: the low 16 form the word, the top stage feeds the chain output
    logic [`SDO_DELAY-1:0] shreg;
    logic [`SDO_DELAY-1:0] next_shreg;
    always_comb begin
        next_shreg = shreg;
        if (!chip_sel_n_i) begin
            next_shreg = {shreg[`SDO_DELAY-2:0], serial_in_i};
        end
    end
    always_ff @(posedge serial_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shreg <= 17'h00000;
        end else begin
            shreg <= next_shreg;
        end
    end
    assign serial_out_o = shreg[`SDO_DELAY-1];

    // word is captured at select rise on its own flop; the clock is stopped then,
    // so the held word stays stable while the system side picks it up
    logic [`WORD_W-1:0] word_hold;
    logic frame_tgl;
    always_ff @(posedge chip_sel_n_i or negedge resetn_i) begin
        if (!resetn_i) begin
            word_hold <= 16'h0000;
            frame_tgl <= 1'b0;
        end else begin
            word_hold <= shreg[`WORD_W-1:0];
            frame_tgl <= ~frame_tgl;
        end
    end

    // ----------------------------------------------------------------
    // system domain
    // ----------------------------------------------------------------
    sys_state_t st;
    sys_state_t next_st;
    logic [2:0] tgl_sync;
    logic [1:0] preset_sync;
    logic frame_done;
    code_bank_t in_regs;
    code_bank_t next_in_regs;
    code_bank_t out_regs;
    code_bank_t next_out_regs;
    code_t preset_code;
    logic [1:0] sel;

    // preset is asynchronous to the clock: take it immediately, release in sync
    always_ff @(posedge ref_clk_i or negedge preset_n_i) begin
        if (!preset_n_i) begin
            preset_sync <= 2'h0;
        end else begin
            preset_sync <= {preset_sync[0], 1'b1};
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tgl_sync <= 3'h0;
        end else begin
            tgl_sync <= {tgl_sync[1:0], frame_tgl};
        end
    end
    assign frame_done = tgl_sync[2] ^ tgl_sync[1];

    assign preset_code = st.level_sync[1] ? `PRESET_HALF : `PRESET_ZERO;
    assign sel = {word_hold[`SEL_HI_BIT], word_hold[`SEL_LO_BIT]};

    always_comb begin
        next_st = st;
        next_st.load_sync = {st.load_sync[0], load_outputs_n_i};
        next_st.level_sync = {st.level_sync[0], preset_level_i};
        // three stages: the level pin needs two edges to settle, so the
        // preset load must still be running once level_sync is valid
        next_st.init_done = {st.init_done[1:0], 1'b1};
        next_in_regs = in_regs;
        next_out_regs = out_regs;
        if (!st.init_done[2] || !preset_sync[1]) begin
            for (int i = 0; i < `NUM_CH; i++) begin
                next_in_regs.ch[i] = preset_code;
                next_out_regs.ch[i] = preset_code;
            end
        end else begin
            if (frame_done) begin
                next_in_regs.ch[sel] = word_hold[`CODE_MSB:0];
            end
            if (!st.load_sync[1]) begin
                next_out_regs = in_regs;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            in_regs <= '0;
            out_regs <= '0;
        end else begin
            st <= next_st;
            in_regs <= next_in_regs;
            out_regs <= next_out_regs;
        end
    end

    // asynchronous preset forces outputs at once, with no clock needed
    generate
        for (genvar g = 0; g < `NUM_CH; g++) begin : g_out
            assign input_regs_o.ch[g] = preset_n_i ? in_regs.ch[g] : preset_code;
            assign dac_regs_o.ch[g] = preset_n_i ? out_regs.ch[g] : preset_code;
        end
    endgenerate

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_shift_hold: assert property (@(posedge serial_clk_i) disable iff (!resetn_i)
        chip_sel_n_i |=> $stable(shreg)) else $error("shift moved while deselected");
    a_chain_delay: assert property (@(posedge serial_clk_i) disable iff (!resetn_i)
        !$past(chip_sel_n_i) |-> (serial_out_o == $past(shreg[15]))
        && (shreg[0] == $past(serial_in_i)))
        else $error("chain output wrong");
    a_frame_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (frame_done && st.init_done[2] && preset_sync[1] && preset_n_i)
        |=> in_regs.ch[$past(sel)] == $past(word_hold[13:0]))
        else $error("input register not loaded");
    a_transparent: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (!st.load_sync[1] && preset_sync[1] && st.init_done[2])
        |=> out_regs == $past(in_regs)) else $error("outputs not following");
    a_hold_out: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (st.load_sync[1] && preset_sync[1] && st.init_done[2]) |=> $stable(out_regs))
        else $error("outputs moved while held");
    a_preset_val: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        !preset_n_i |-> dac_regs_o.ch[0] == (st.level_sync[1] ? 14'h2000 : 14'h0000))
        else $error("preset value wrong");
    a_preset_all: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        !preset_sync[1] |=> in_regs == {4{preset_code}} || $changed(st.level_sync[1]))
        else $error("preset missed a register");
    a_init_preset: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        $rose(st.init_done[2]) |-> out_regs.ch[3] == $past(preset_code))
        else $error("init preset missing");
endmodule

/* File: dv/quad_dac_host.sv */
// serial master model driving the converter link
`timescale 1ns/10ps
module quad_dac_host (
    // serial link
    output logic serial_clk_o,
    output logic chip_sel_n_o,
    output logic serial_in_o
);
    initial begin
        serial_clk_o = 1'b0;
        chip_sel_n_o = 1'b1;
        serial_in_o = 1'b0;
    end
    // clock stands still outside frames except in stay_high sends; released data is inverted, never held
    task automatic send(input logic [23:0] w, input int n, input logic stay_high);
        chip_sel_n_o = stay_high;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in_o = w[i];
            #62.5 serial_clk_o = 1'b1;
            #62.5 serial_clk_o = 1'b0;
        end
        // select rises 40 ns after the last clock fall of each word sent with select low
        #40 chip_sel_n_o = 1'b1;
        serial_in_o = ~serial_in_o;
        #200;
    endtask
endmodule

/* File: dv/quad_dac_serial_load_logic_tb.sv */
// self-checking bench of the quad converter serial load logic
`timescale 1ns/10ps
module quad_dac_serial_load_logic_tb;
    import quad_dac_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic load_n = 1'b1;
    logic preset_n = 1'b1;
    logic level = 1'b1;
    wire logic sclk, cs_n, serial_in, serial_out;
    code_bank_t in_regs, dac_regs, exp_in, exp_dac;
    code_t codes [4] = '{14'h3fff, 14'h0001, 14'h1555, 14'h2aaa};
    int n_mismatch = 0;
    int total_checks = 0;
    always #12.5 ref_clk = ~ref_clk;
    quad_dac_host i_host (.serial_clk_o(sclk), .chip_sel_n_o(cs_n), .serial_in_o(serial_in));
    quad_dac_serial_load_logic i_dut (.ref_clk_i(ref_clk), .resetn_i(resetn),
        .serial_clk_i(sclk), .chip_sel_n_i(cs_n), .serial_in_i(serial_in), .serial_out_o(serial_out),
        .load_outputs_n_i(load_n), .preset_n_i(preset_n), .preset_level_i(level),
        .input_regs_o(in_regs), .dac_regs_o(dac_regs));
    // ----------------------------------------
    // checking tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [55:0] exp, input logic [55:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // updates land within 5 edges of their cause; 10 leaves margin
    task automatic regs(input string what);
        repeat (10) @(negedge ref_clk);
        chk({what, " input regs"}, exp_in, in_regs);
        chk({what, " dac regs"}, exp_dac, dac_regs);
        $display("test %s done", what);
    endtask
    task automatic wr(input logic [1:0] ch, input code_t code);
        i_host.send({8'h00, ch, code}, 16, 1'b0);
        exp_in.ch[ch] = code;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge ref_clk);
        resetn = 1'b1;
        exp_in = {4{14'h2000}};
        exp_dac = exp_in;
        regs("power up");
        for (int c = 0; c < 4; c++) begin
            wr(2'(c), codes[c]);
        end
        regs("address decode");
        // eight stale bits lead the word; bit 16 of the stream is a one
        i_host.send(24'h5da122, 24, 1'b0);
        exp_in.ch[2] = 14'h2122;
        chk("serial out", 56'h1, {55'h0, serial_out});
        regs("extra bits");
        i_host.send(24'h00ffff, 16, 1'b1);
        chk("serial out held", 56'h1, {55'h0, serial_out});
        regs("deselected clocks");
        @(negedge ref_clk);
        load_n = 1'b0;
        exp_dac = exp_in;
        regs("transparent");
        wr(2'd1, 14'h0777);
        exp_dac = exp_in;
        regs("follow");
        load_n = 1'b1;
        wr(2'd3, 14'h0010);
        regs("hold");
        level = 1'b0;
        preset_n = 1'b0;
        exp_in = '0;
        exp_dac = '0;
        regs("preset zero");
        level = 1'b1;
        exp_in = {4{14'h2000}};
        exp_dac = exp_in;
        regs("preset half");
        preset_n = 1'b1;
        regs("preset released");
        print_verdict();
    end
endmodule
